// file: logic/osc_consts.svh
// constants for the clock source select and trim sequencer
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH
`define ADR_CTRL 4'h0
`define ADR_TUNE1 4'h4
`define ADR_TUNE2 4'h8
`define ADR_STAT 4'hc
`define CTRL_SEQ_EN 0
`define CTRL_LOCK 1
`define CTRL_READY 2
`define CTRL_SRC_LO 4
`define STAT_TRIM_LO 8
`define TUNE_RST 16'h0000
`define STARTUP_CYCLES 11'h400
`define STARTUP_TC 10'h3ff
`define PLL_GAIN 6'h20
`define ROLL_SEL_HI 5
`define ROLL_SEL_LO 3
`define GRP_RC 2'h0
`define GRP_RC_PLL 2'h1
`define GRP_PRI 2'h2
`define GRP_PRI_PLL 2'h3
`define PMODE_EXT 2'h0
`define PMODE_XTAL 2'h2
`define PMODE_OFF 2'h3
`endif

// file: logic/osc_pkg.sv
// types and mode decoding for the clock source select block
`include "osc_consts.svh"
package osc_pkg;
   typedef enum logic [2:0] {
      MODE_RC = 3'h0,
      MODE_RC_PLL = 3'h1,
      MODE_XTAL = 3'h2,
      MODE_EXT = 3'h3,
      MODE_EXT_PLL = 3'h6,
      MODE_XTAL_PLL = 3'h7
   } clk_mode_e;

   typedef enum logic [1:0] {
      ST_RESET = 2'h0,
      ST_CAPTURE = 2'h1,
      ST_START = 2'h3,
      ST_RUN = 2'h2
   } seq_state_e;

   function automatic logic is_pll(input clk_mode_e m);
      return m == MODE_RC_PLL || m == MODE_EXT_PLL || m == MODE_XTAL_PLL;
   endfunction

   function automatic logic is_xtal(input clk_mode_e m);
      return m == MODE_XTAL || m == MODE_XTAL_PLL;
   endfunction

   function automatic logic is_rc(input clk_mode_e m);
      return m == MODE_RC || m == MODE_RC_PLL;
   endfunction
endpackage

// file: logic/trim_if.sv
// carrier between the sequencer and the trim multiplexer
`timescale 1ns/1ps
`default_nettype none
interface trim_if;
   logic seq_en;
   logic [2:0] sel;
   logic [31:0] fields;
   logic [3:0] trim;
   modport mux (input seq_en, input sel, input fields, output trim);
   modport ctrl (output seq_en, output sel, output fields, input trim);
endinterface
`default_nettype wire

// file: logic/startup_timer.sv
// oscillator start-up delay counter
`timescale 1ns/1ps
`default_nettype none
`include "osc_consts.svh"
module startup_timer
   import osc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic restart_i,
   output logic done_o
);
   logic [9:0] cnt_r;
   logic done_r;

   always_ff @(posedge clk_i) begin
      if (rst_i || restart_i) begin
         cnt_r <= 10'h000;
         done_r <= 1'b0;
      end else if (!done_r) begin
         if (cnt_r == `STARTUP_TC) begin
            done_r <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 10'h001;
         end
      end
   end

   assign done_o = done_r;

   a_restart_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      restart_i |=> (cnt_r == 10'h000 && !done_o))
      else $error("start-up counter not cleared on restart");

   a_done_at_tc: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(done_o) |-> $past(cnt_r) == `STARTUP_TC)
      else $error("start-up done before terminal count");
endmodule
`default_nettype wire

// file: logic/trim_mux.sv
// eight-way trim value multiplexer with registered output
`timescale 1ns/1ps
`default_nettype none
module trim_mux
   import osc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // trim fields and select
   trim_if.mux tif
);
   logic [3:0] nib [8];
   logic [3:0] trim_r;

   // nibble 0 is the user trim and the first sequence value, 1..7 the rest of the sequence
   for (genvar i = 0; i < 8; i++) begin : g_nib
      assign nib[i] = tif.fields[i*4 +: 4];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trim_r <= 4'h0;
      end else if (tif.seq_en) begin
         trim_r <= nib[tif.sel];
      end else begin
         trim_r <= nib[0];
      end
   end

   assign tif.trim = trim_r;

   a_user_trim_only: assert property (@(posedge clk_i) disable iff (rst_i)
      !tif.seq_en |=> tif.trim == $past(tif.fields[3:0]))
      else $error("user trim not applied with sequencing off");

   a_seq_upper: assert property (@(posedge clk_i) disable iff (rst_i)
      (tif.seq_en && tif.sel[2]) |=>
      tif.trim == $past(tif.fields[16 + tif.sel[1:0]*4 +: 4]))
      else $error("upper sequence field not routed");
endmodule
`default_nettype wire

// file: logic/osc_select_trim_sequencer.sv
// clock source selection, start-up delay and rc trim sequencing
`timescale 1ns/1ps
`default_nettype none
`include "osc_consts.svh"
module osc_select_trim_sequencer
   import osc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // configuration straps
   input wire logic [1:0] cfg_osc_group_sel_i,
   input wire logic [1:0] cfg_primary_osc_mode_i,
   input wire logic cfg_osc_out_pin_func_i,
   input wire logic cfg_freq_range_i,
   // events on this clock
   input wire logic wake_i,
   input wire logic pwm_rollover_i,
   // asynchronous status
   input wire logic pll_lock_i,
   input wire logic clk_fail_i,
   // second oscillator pin
   input wire logic osc_out_pin_i,
   output logic osc_out_pin_o,
   output logic osc_out_pin_oe_o,
   input wire logic gpio_out_i,
   input wire logic gpio_oe_i,
   output logic gpio_in_o,
   // oscillator and pll control
   output logic osc_in_pin_is_gpio_o,
   output logic xtal_drive_en_o,
   output logic frc_enable_o,
   output logic frc_range_o,
   output logic [3:0] frc_trim_o,
   output logic pll_enable_o,
   output logic [5:0] pll_gain_o,
   output logic pll_locked_o,
   output logic sys_clk_release_o,
   output logic [2:0] clk_source_o
);
   ////////////////////////////////////////////////////////////////////
   // declarations
   ////////////////////////////////////////////////////////////////////
   seq_state_e state_r, state_nxt;
   clk_mode_e mode_r;
   logic pin_func_r, range_r, lock_r, seq_en_r;
   logic [2:0] sync1_r, sync2_r;
   logic [15:0] tune1_r, tune2_r;
   logic [5:0] roll_r;
   logic ack_r;
   logic [31:0] dat_r;
   logic pin_out_r, pin_oe_r, gpio_in_r, in_gpio_r;
   logic xtal_r, frc_en_r, pll_en_r, release_r;
   logic restart, timer_done, clkout_en, out_is_gpio, wr, fail_s;

   trim_if tif ();

   ////////////////////////////////////////////////////////////////////
   // strap decode
   ////////////////////////////////////////////////////////////////////
   // unlisted strap pairs fall back to the rc source so the part runs
   function automatic clk_mode_e decode_mode(input logic [1:0] grp,
                                             input logic [1:0] pm);
      clk_mode_e m;
      m = MODE_RC;
      case (grp)
         `GRP_PRI_PLL: begin
            if (pm == `PMODE_XTAL) begin
               m = MODE_XTAL_PLL;
            end else if (pm == `PMODE_EXT) begin
               m = MODE_EXT_PLL;
            end
         end
         `GRP_PRI: begin
            if (pm == `PMODE_XTAL) begin
               m = MODE_XTAL;
            end else if (pm == `PMODE_EXT) begin
               m = MODE_EXT;
            end
         end
         `GRP_RC_PLL: begin
            if (pm == `PMODE_OFF) begin
               m = MODE_RC_PLL;
            end
         end
         default: begin
            m = MODE_RC;
         end
      endcase
      return m;
   endfunction
   ////////////////////////////////////////////////////////////////////
   // synchronisers for asynchronous inputs
   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
      end else begin
         sync1_r <= {osc_out_pin_i, clk_fail_i, pll_lock_i};
         sync2_r <= sync1_r;
      end
   end

   assign fail_s = sync2_r[1];
   ////////////////////////////////////////////////////////////////////
   // start-up sequence
   ////////////////////////////////////////////////////////////////////
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RESET: begin
            state_nxt = ST_CAPTURE;
         end
         ST_CAPTURE: begin
            state_nxt = ST_START;
         end
         ST_START: begin
            // only a crystal waits for the counter
            if (!is_xtal(mode_r) || timer_done) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (wake_i) begin
               state_nxt = ST_START;
            end
         end
         default: begin
            state_nxt = ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= ST_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // straps are caught two cycles after reset release, never under reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_r <= MODE_RC;
         pin_func_r <= 1'b0;
         range_r <= 1'b0;
      end else if (state_r == ST_CAPTURE) begin
         mode_r <= decode_mode(cfg_osc_group_sel_i,
                               cfg_primary_osc_mode_i);
         pin_func_r <= cfg_osc_out_pin_func_i;
         range_r <= cfg_freq_range_i;
      end
   end

   assign restart = (state_r == ST_CAPTURE) || (state_r == ST_RUN && wake_i);
   startup_timer u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .restart_i(restart),
      .done_o(timer_done)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         release_r <= 1'b0;
      end else begin
         release_r <= (state_nxt == ST_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // oscillator, pll and pin control
   ////////////////////////////////////////////////////////////////////
   // crystal modes keep the pin as the crystal drive, so no clock out
   assign clkout_en = pin_func_r && !is_xtal(mode_r)
                      && state_r != ST_RESET && state_r != ST_CAPTURE;
   assign out_is_gpio = !pin_func_r && !is_xtal(mode_r);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_out_r <= 1'b0;
         pin_oe_r <= 1'b0;
      end else if (clkout_en) begin
         pin_out_r <= !pin_out_r;
         pin_oe_r <= 1'b1;
      end else if (out_is_gpio) begin
         pin_out_r <= gpio_out_i;
         pin_oe_r <= gpio_oe_i;
      end else begin
         pin_out_r <= 1'b0;
         pin_oe_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_gpio_r <= 1'b0;
         xtal_r <= 1'b0;
         frc_en_r <= 1'b1;
         pll_en_r <= 1'b0;
         lock_r <= 1'b0;
         gpio_in_r <= 1'b0;
      end else begin
         in_gpio_r <= is_rc(mode_r);
         xtal_r <= is_xtal(mode_r);
         frc_en_r <= is_rc(mode_r) || fail_s;
         pll_en_r <= is_pll(mode_r);
         lock_r <= sync2_r[0];
         gpio_in_r <= sync2_r[2];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // rollover count and trim selection
   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         roll_r <= 6'h00;
      end else if (pwm_rollover_i) begin
         roll_r <= roll_r + 6'h01;
      end
   end

   assign tif.seq_en = seq_en_r;
   assign tif.sel = roll_r[`ROLL_SEL_HI:`ROLL_SEL_LO];
   assign tif.fields = {tune2_r, tune1_r};
   trim_mux u_mux (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tif(tif)
   );

   ////////////////////////////////////////////////////////////////////
   // wishbone registers
   ////////////////////////////////////////////////////////////////////
   // one wait state: ack rises the cycle after the strobe
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq_en_r <= 1'b0;
         tune1_r <= `TUNE_RST;
         tune2_r <= `TUNE_RST;
      end else if (wr) begin
         case (wb_adr_i)
            `ADR_CTRL: begin
               if (wb_sel_i[0]) begin
                  seq_en_r <= wb_dat_i[`CTRL_SEQ_EN];
               end
            end
            `ADR_TUNE1: begin
               if (wb_sel_i[0]) begin
                  tune1_r[7:0] <= wb_dat_i[7:0];
               end
               if (wb_sel_i[1]) begin
                  tune1_r[15:8] <= wb_dat_i[15:8];
               end
            end
            `ADR_TUNE2: begin
               if (wb_sel_i[0]) begin
                  tune2_r[7:0] <= wb_dat_i[7:0];
               end
               if (wb_sel_i[1]) begin
                  tune2_r[15:8] <= wb_dat_i[15:8];
               end
            end
            default: begin
               seq_en_r <= seq_en_r;
            end
         endcase
      end
   end

   // unmapped offsets still ack and read as zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_r <= 32'h0000_0000;
      end else begin
         dat_r <= 32'h0000_0000;
         case (wb_adr_i)
            `ADR_CTRL: begin
               dat_r[`CTRL_SEQ_EN] <= seq_en_r;
               dat_r[`CTRL_LOCK] <= lock_r;
               dat_r[`CTRL_READY] <= release_r;
               dat_r[`CTRL_SRC_LO +: 3] <= mode_r;
            end
            `ADR_TUNE1: begin
               dat_r[15:0] <= tune1_r;
            end
            `ADR_TUNE2: begin
               dat_r[15:0] <= tune2_r;
            end
            `ADR_STAT: begin
               dat_r[5:0] <= roll_r;
               dat_r[`STAT_TRIM_LO +: 4] <= tif.trim;
            end
            default: begin
               dat_r <= 32'h0000_0000;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   ////////////////////////////////////////////////////////////////////
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign osc_out_pin_o = pin_out_r;
   assign osc_out_pin_oe_o = pin_oe_r;
   assign gpio_in_o = gpio_in_r;
   assign osc_in_pin_is_gpio_o = in_gpio_r;
   assign xtal_drive_en_o = xtal_r;
   assign frc_enable_o = frc_en_r;
   assign frc_range_o = range_r;
   assign frc_trim_o = tif.trim;
   assign pll_enable_o = pll_en_r;
   assign pll_gain_o = `PLL_GAIN;
   assign pll_locked_o = lock_r;
   assign sys_clk_release_o = release_r;
   assign clk_source_o = mode_r;
   ////////////////////////////////////////////////////////////////////
   // checks
   ////////////////////////////////////////////////////////////////////
   a_lock_mirror: assert property (@(posedge clk_i) disable iff (rst_i)
      sync2_r[0] |=> pll_locked_o) else $error("lock not mirrored");
   a_clkout_div2: assert property (@(posedge clk_i) disable iff (rst_i)
      (clkout_en && $past(clkout_en)) |=> osc_out_pin_o != $past(osc_out_pin_o))
      else $error("clock out is not divided by two");
   a_ext_gpio: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_r == MODE_EXT && !pin_func_r && !gpio_oe_i) |=> !osc_out_pin_oe_o)
      else $error("second pin driven in external I/O mode");
   a_rc_power: assert property (@(posedge clk_i) disable iff (rst_i)
      (is_rc(mode_r) || fail_s) |=> frc_enable_o)
      else $error("rc oscillator off when needed");
   a_pll_on: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == ST_RUN && is_pll(mode_r)) |=> pll_enable_o)
      else $error("pll not enabled in pll mode");
   a_xtal_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == ST_START && is_xtal(mode_r) && !timer_done) |=>
      !sys_clk_release_o)
      else $error("crystal clock released before count");
   a_rc_in_gpio: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == ST_RUN && is_rc(mode_r)) |=> osc_in_pin_is_gpio_o)
      else $error("first pin not I/O in rc mode");
endmodule
`default_nettype wire

// file: test/osc_source_model.sv
// far-side model: clock source on the pins and the pll lock output
`timescale 1ns/1ps
`default_nettype none
module osc_source_model #(
   parameter int LOCK_DLY = 4
) (
   // clock
   input wire logic clk_i,
   // device side of the second pin and the pll
   input wire logic pll_en_i,
   input wire logic dev_oe_i,
   input wire logic dev_out_i,
   // bench commands
   input wire logic drive_en_i,
   input wire logic drive_val_i,
   input wire logic drop_lock_i,
   // pin level and lock
   output logic pin_o,
   output logic lock_o
);
   logic [7:0] lock_cnt_r;
   logic float_r;

   initial begin
      lock_cnt_r = 8'h00;
      float_r = 1'b0;
   end

   // lock needs the pll powered for a while; noise can knock it out
   always @(posedge clk_i) begin
      float_r <= ~float_r;
      if (!pll_en_i || drop_lock_i) begin
         lock_cnt_r <= 8'h00;
      end else if (lock_cnt_r < 8'(LOCK_DLY)) begin
         lock_cnt_r <= lock_cnt_r + 8'h01;
      end
   end

   assign lock_o = (lock_cnt_r == 8'(LOCK_DLY));
   // an undriven line has no pull: show a changing level, not a held one
   assign pin_o = dev_oe_i ? dev_out_i : (drive_en_i ? drive_val_i : float_r);
endmodule
`default_nettype wire

// file: test/osc_select_trim_sequencer_tb.sv
// self-checking bench for the clock source select and trim sequencer
`timescale 1ns/1ps
`default_nettype none
`include "osc_consts.svh"
module osc_select_trim_sequencer_tb
   import osc_pkg::*;
;
   localparam int NM = 11;
   localparam int LIMIT = 20000;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [1:0] cfg_osc_group_sel_i = 2'h0;
   logic [1:0] cfg_primary_osc_mode_i = 2'h0;
   logic cfg_osc_out_pin_func_i = 1'b0;
   logic cfg_freq_range_i = 1'b0;
   logic wake_i = 1'b0;
   logic pwm_rollover_i = 1'b0;
   logic clk_fail_i = 1'b0;
   logic gpio_out_i = 1'b0;
   logic gpio_oe_i = 1'b0;
   logic drive_en = 1'b0;
   logic drive_val = 1'b0;
   logic drop_lock = 1'b0;
   wire pll_lock_i;
   wire osc_out_pin_i;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, osc_out_pin_o, osc_out_pin_oe_o, gpio_in_o;
   logic osc_in_pin_is_gpio_o, xtal_drive_en_o, frc_enable_o, frc_range_o;
   logic [3:0] frc_trim_o;
   logic pll_enable_o, pll_locked_o, sys_clk_release_o;
   logic [5:0] pll_gain_o;
   logic [2:0] clk_source_o;
   int bad_count = 0;
   int n_tests = 0;
   int cyc_cnt = 0;
   integer seed = 32'hbaed;
   logic [31:0] exp_q[$];
   logic [31:0] r, seq_all;
   logic [5:0] rcnt;
   logic [3:0] e4;
   logic xt, rc, pl, fn, b;
   clk_mode_e m;
   // {group, primary mode, pin function} and the source it must give
   logic [4:0] cfg_t [NM] = '{5'b11100, 5'b01111, 5'b01110, 5'b11001,
      5'b11000, 5'b10001, 5'b10000, 5'b10100, 5'b00110, 5'b00111, 5'b10010};
   clk_mode_e mode_t [NM] = '{MODE_XTAL_PLL, MODE_RC_PLL, MODE_RC_PLL,
      MODE_EXT_PLL, MODE_EXT_PLL, MODE_EXT, MODE_EXT, MODE_XTAL, MODE_RC,
      MODE_RC, MODE_RC};

   always #5 clk_i = ~clk_i;

   osc_select_trim_sequencer dut (
      .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .cfg_osc_group_sel_i,
      .cfg_primary_osc_mode_i, .cfg_osc_out_pin_func_i, .cfg_freq_range_i,
      .wake_i, .pwm_rollover_i, .pll_lock_i, .clk_fail_i, .osc_out_pin_i,
      .osc_out_pin_o, .osc_out_pin_oe_o, .gpio_out_i, .gpio_oe_i, .gpio_in_o,
      .osc_in_pin_is_gpio_o, .xtal_drive_en_o, .frc_enable_o, .frc_range_o,
      .frc_trim_o, .pll_enable_o, .pll_gain_o, .pll_locked_o,
      .sys_clk_release_o, .clk_source_o);

   osc_source_model #(.LOCK_DLY(4)) src (
      .clk_i, .pll_en_i(pll_enable_o), .dev_oe_i(osc_out_pin_oe_o),
      .dev_out_i(osc_out_pin_o), .drive_en_i(drive_en),
      .drive_val_i(drive_val), .drop_lock_i(drop_lock),
      .pin_o(osc_out_pin_i), .lock_o(pll_lock_i));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // request held until ack is sampled high, then one idle cycle
   task automatic wb_xfer(input logic we, input logic [3:0] adr,
                          input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'h3;
      wb_dat_i <= d;
      // no local limit: only the bench timeout ends a hung wait
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
      chk("wb_ack_drop", 32'h0, wb_ack_o);
   endtask

   task automatic wb_rd(input logic [3:0] adr, input logic [31:0] e);
      exp_q.push_back(e);
      wb_xfer(1'b0, adr, 32'h0000_0000);
   endtask

   task automatic pwm_pulse;
      pwm_rollover_i <= 1'b1;
      @(posedge clk_i);
      pwm_rollover_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // oldest noted read value against what the ack carries
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         if (exp_q.size() == 0) chk("rd_extra", 32'h0, 32'h1);
         else chk("rd_data", exp_q.pop_front(), wb_dat_o);
      end
   end

   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == LIMIT) begin
         bad_count++;
         stop_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      for (int i = 0; i < NM; i++) begin
         m = mode_t[i];
         xt = (m == MODE_XTAL) || (m == MODE_XTAL_PLL);
         rc = (m == MODE_RC) || (m == MODE_RC_PLL);
         pl = (m == MODE_RC_PLL) || (m == MODE_EXT_PLL) || (m == MODE_XTAL_PLL);
         fn = cfg_t[i][0];
         {cfg_osc_group_sel_i, cfg_primary_osc_mode_i,
          cfg_osc_out_pin_func_i} <= cfg_t[i];
         cfg_freq_range_i <= i[0];
         drive_en <= !fn && !xt;
         rst_i <= 1'b1;
         wait_cyc(5);
         chk("held", 32'h0, sys_clk_release_o);
         rst_i <= 1'b0;
         if (xt) begin
            wait_cyc(`STARTUP_CYCLES + 1);
            chk("early", 32'h0, sys_clk_release_o);
         end
         wait_cyc(12);
         chk("release", 32'h1, sys_clk_release_o);
         wait_cyc(4);
         chk("mode", m, clk_source_o);
         chk("pll_en", pl, pll_enable_o);
         chk("gain", 32'h20, pll_gain_o);
         chk("lock", pl, pll_locked_o);
         chk("frc_en", rc, frc_enable_o);
         chk("in_gpio", rc, osc_in_pin_is_gpio_o);
         chk("xtal_drv", xt, xtal_drive_en_o);
         chk("range", i[0], frc_range_o);
         wb_rd(`ADR_CTRL, {25'h0, m, 1'b0, 1'b1, pl, 1'b0});
         r = $random(seed);
         gpio_out_i <= r[0];
         gpio_oe_i <= r[1];
         drive_val <= r[2];
         wait_cyc(5);
         if (xt) begin
            chk("pin_oe", 32'h0, osc_out_pin_oe_o);
         end else if (fn) begin
            chk("pin_oe", 32'h1, osc_out_pin_oe_o);
            b = osc_out_pin_o;
            @(posedge clk_i);
            chk("clk_out", !b, osc_out_pin_o);
         end else begin
            chk("pin_oe", gpio_oe_i, osc_out_pin_oe_o);
            chk("pin_out", gpio_out_i, osc_out_pin_o);
            chk("pin_in", gpio_oe_i ? gpio_out_i : drive_val, gpio_in_o);
         end
         if (pl) begin
            drop_lock <= 1'b1;
            wait_cyc(6);
            chk("lock_lost", 32'h0, pll_locked_o);
            drop_lock <= 1'b0;
            wait_cyc(10);
            chk("relock", 32'h1, pll_locked_o);
         end
         if (xt) begin
            clk_fail_i <= 1'b1;
            wait_cyc(6);
            chk("fail_frc", 32'h1, frc_enable_o);
            clk_fail_i <= 1'b0;
            wake_i <= 1'b1;
            @(posedge clk_i);
            wake_i <= 1'b0;
            wait_cyc(4);
            chk("wake_drop", 32'h0, sys_clk_release_o);
            wait_cyc(`STARTUP_CYCLES - 4);
            chk("wake_early", 32'h0, sys_clk_release_o);
            wait_cyc(12);
            chk("wake_rel", 32'h1, sys_clk_release_o);
         end
         $display("test mode %0d done", i);
      end
      // trim sequencing, plain rc mode from the last entry
      r = $random(seed);
      seq_all = r;
      wb_xfer(1'b1, `ADR_TUNE1, {16'hffff, seq_all[15:0]});
      wb_xfer(1'b1, `ADR_TUNE2, {16'hffff, seq_all[31:16]});
      wb_rd(`ADR_TUNE1, {16'h0000, seq_all[15:0]});
      wb_rd(`ADR_TUNE2, {16'h0000, seq_all[31:16]});
      wb_rd(4'h2, 32'h0000_0000);
      rcnt = 6'h00;
      repeat (8) begin
         pwm_pulse();
         rcnt++;
      end
      wait_cyc(2);
      chk("trim_user", seq_all[3:0], frc_trim_o);
      wb_xfer(1'b1, `ADR_CTRL, 32'h0000_00f7);
      wb_rd(`ADR_CTRL, {25'h0, MODE_RC, 4'h5});
      for (int k = 0; k < 64; k++) begin
         e4 = seq_all[rcnt[5:3] * 4 +: 4];
         chk("trim_seq", e4, frc_trim_o);
         if (rcnt[2:0] == 3'h0) wb_rd(`ADR_STAT, {20'h0, e4, 2'b0, rcnt});
         pwm_pulse();
         rcnt++;
         wait_cyc(2);
      end
      $display("test trim done");
      wait_cyc(3);
      chk("rd_left", 32'h0, exp_q.size());
      stop_test();
   end
endmodule
`default_nettype wire
